// ===== tsitx_dev.sv
`timescale 1ns/10ps
// How it works
// - Each Tx slot picks its delay mode
// - Low delay needs two slots plus (4+i) units
// - Too close or earlier goes next frame
// - Zero offsets: slot 31 N, slot 2 N+1
// - Preserved slots of one frame leave together
// - Preserved delay stays under 378 microseconds
// - Preservation holds per Rx/Tx highway pair
// - Preserved frame set by offset difference only
// - Difference at least C gives N+1
// - Difference below B gives N+3
// - Other differences give N+2
// - Offsets settable up to frame minus quarter bit
// - Boundaries may shift one fast slot
// - Same Rx offsets give equal delay
// - Upper style nibble picks one of 16 pattern codes
// - Source select 110 takes generator data
// - Other slots keep normal sourcing
// - Host marks one contiguous run only
// - User byte register feeds fixed pattern
// - Start bit alone starts generator; rate field unused
// - Send only with both transmit enables
// - Host clears old marks before moving
module tsitx_dev
  import tsitx_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Device end of the link
  tsitx_if.dev lnk
);

  logic [7:0] global_command_r;
  logic [7:0] test_command_r;
  logic [7:0] pattern_style_r;
  logic [7:0] gen_user_byte_r;
  logic [7:0] tx_cfg0_r;
  logic [7:0] tx_cfg1_r;
  logic [7:0] tx_cfg2_r;
  logic [7:0] rx_cfg0_r;
  logic [7:0] rx_cfg1_r;
  logic [15:0] cs_mem [NUM_SLOTS];
  logic [7:0] ds_mem [4*NUM_SLOTS];
  logic ack_r;
  logic [7:0] rdata_r;
  logic [11:0] unit_r;
  logic [1:0] phys_r;
  logic [14:0] lfsr_r;
  logic [7:0] tx_data_r;
  logic tx_stb_r;
  logic tx_oe_r;

  // Pattern source for a substituted slot
  function automatic logic [7:0] pat_byte(input logic [3:0] sel, input logic [14:0] lf,
                                          input logic [7:0] user);
    case (sel)
      4'h0: pat_byte = 8'h00;
      4'h1: pat_byte = 8'hff;
      4'h2: pat_byte = 8'h55;
      4'h3: pat_byte = 8'haa;
      4'h4: pat_byte = 8'h0f;
      4'h5: pat_byte = 8'hf0;
      4'h6: pat_byte = ~lf[7:0];
      PAT_USER_BYTE: pat_byte = user;
      default: pat_byte = lf[7:0];
    endcase
  endfunction

  function automatic logic [14:0] lfsr_step8(input logic [14:0] lf);
    logic [14:0] v;
    v = lf;
    for (int k = 0; k < 8; k++) begin
      v = {v[13:0], v[14] ^ v[13]};
    end
    lfsr_step8 = v;
  endfunction

  // Offsets in 30.5176 ns units, 0 to 4095
  wire [11:0] tx_off = {tx_cfg1_r[3:0], tx_cfg0_r};
  wire [11:0] rx_off = {rx_cfg1_r[3:0], rx_cfg0_r};
  wire [4:0] hw_index = tx_cfg2_r[7:HW_INDEX_LSB];
  wire [11:0] rel_rx = unit_r - rx_off;
  wire [11:0] rel_tx = unit_r - tx_off;
  // Virtual frame number: a highway whose offset has not yet been reached
  // in this physical frame is still in the previous virtual frame
  wire [1:0] rx_vf = phys_r - {1'b0, (unit_r < rx_off)};
  wire [1:0] tx_vf = phys_r - {1'b0, (unit_r < tx_off)};
  wire rx_slot_done = (rel_rx[6:0] == 7'h7f);
  wire [4:0] rx_slot = rel_rx[11:7];
  wire tx_slot_start = (rel_tx[6:0] == 7'h00);
  wire [4:0] tx_slot = rel_tx[11:7];

  wire [15:0] cs_entry = cs_mem[tx_slot];
  wire [4:0] cs_src = cs_entry[4:0];
  wire cs_fp = cs_entry[CS_FP_BIT];
  wire [2:0] cs_sel = cs_entry[CS_SRC_SEL_LSB +: 3];
  wire cs_pattern = (cs_sel == SRC_SEL_PATTERN);

  // Low delay: Tx position against Rx position plus guard
  wire [12:0] tx_pos = {tx_slot, 7'h00} + {1'b0, tx_off};
  wire [13:0] ll_need = {9'h000, cs_src} * 14'(SLOT_UNITS) + {2'b00, rx_off}
                        + {1'b0, LL_GAP_SLOTS} + {1'b0, LL_GAP_FIXED}
                        + {9'h000, hw_index};
  wire ll_late = ({1'b0, tx_pos} < ll_need);

  // Preserved delay depends on the signed offset difference only
  wire signed [12:0] off_diff = $signed({1'b0, tx_off}) - $signed({1'b0, rx_off});
  wire [1:0] fp_delay = (off_diff >= BOUND_C) ? 2'd1 :
                        (off_diff < BOUND_B) ? 2'd3 :
                        2'd2;
  // Worst case is three frames minus one slot, inside 378 us
  wire [1:0] slot_delay = cs_fp ? fp_delay : {1'b0, ll_late};
  wire [1:0] rd_bank = tx_vf - slot_delay;
  wire [7:0] switched_byte = ds_mem[{rd_bank, cs_src}];

  wire gen_on = test_command_r[GEN_START_BIT];
  wire [7:0] gen_byte = gen_on ? pat_byte(pattern_style_r[7:PAT_SEL_LSB], lfsr_r,
                                          gen_user_byte_r) : GEN_IDLE_BYTE;
  wire [7:0] slot_byte = cs_pattern ? gen_byte : switched_byte;
  wire tx_enabled = global_command_r[GLOBAL_TX_EN_BIT] & tx_cfg2_r[HW_TX_EN_BIT];

  // Register port decode
  wire rq_new = lnk.rq & ~ack_r;
  wire wr_go = rq_new & lnk.rq_we;
  wire cs_hit = (lnk.rq_addr[13:6] == CS_BASE[13:6]);
  wire [4:0] cs_idx = lnk.rq_addr[5:1];
  wire [15:0] cs_rd = cs_mem[cs_idx];
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = REG_RESET;
    if (lnk.rq_addr == REG_GLOBAL_COMMAND) begin
      rd_mux = global_command_r;
    end else if (lnk.rq_addr == REG_TEST_COMMAND) begin
      rd_mux = test_command_r;
    end else if (lnk.rq_addr == REG_PATTERN_STYLE) begin
      rd_mux = pattern_style_r;
    end else if (lnk.rq_addr == REG_GEN_USER_BYTE) begin
      rd_mux = gen_user_byte_r;
    end else if (lnk.rq_addr == REG_TX_CFG_BYTE0) begin
      rd_mux = tx_cfg0_r;
    end else if (lnk.rq_addr == REG_TX_CFG_BYTE1) begin
      rd_mux = tx_cfg1_r;
    end else if (lnk.rq_addr == REG_TX_CFG_BYTE2) begin
      rd_mux = tx_cfg2_r;
    end else if (lnk.rq_addr == REG_RX_CFG_BYTE0) begin
      rd_mux = rx_cfg0_r;
    end else if (lnk.rq_addr == REG_RX_CFG_BYTE1) begin
      rd_mux = rx_cfg1_r;
    end else if (cs_hit) begin
      rd_mux = lnk.rq_addr[0] ? cs_rd[15:8] : cs_rd[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ack_r <= 1'b0;
      rdata_r <= REG_RESET;
    end else begin
      ack_r <= rq_new;
      if (rq_new) begin
        rdata_r <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      global_command_r <= REG_RESET;
      test_command_r <= REG_RESET;
      pattern_style_r <= REG_RESET;
      gen_user_byte_r <= REG_RESET;
      tx_cfg0_r <= REG_RESET;
      tx_cfg1_r <= REG_RESET;
      tx_cfg2_r <= REG_RESET;
      rx_cfg0_r <= REG_RESET;
      rx_cfg1_r <= REG_RESET;
    end else if (wr_go) begin
      if (lnk.rq_addr == REG_GLOBAL_COMMAND) begin
        global_command_r <= lnk.rq_wdata;
      end else if (lnk.rq_addr == REG_TEST_COMMAND) begin
        test_command_r <= lnk.rq_wdata;
      end else if (lnk.rq_addr == REG_PATTERN_STYLE) begin
        pattern_style_r <= lnk.rq_wdata;
      end else if (lnk.rq_addr == REG_GEN_USER_BYTE) begin
        gen_user_byte_r <= lnk.rq_wdata;
      end else if (lnk.rq_addr == REG_TX_CFG_BYTE0) begin
        tx_cfg0_r <= lnk.rq_wdata;
      end else if (lnk.rq_addr == REG_TX_CFG_BYTE1) begin
        tx_cfg1_r <= lnk.rq_wdata;
      end else if (lnk.rq_addr == REG_TX_CFG_BYTE2) begin
        tx_cfg2_r <= lnk.rq_wdata;
      end else if (lnk.rq_addr == REG_RX_CFG_BYTE0) begin
        rx_cfg0_r <= lnk.rq_wdata;
      end else if (lnk.rq_addr == REG_RX_CFG_BYTE1) begin
        rx_cfg1_r <= lnk.rq_wdata;
      end
    end
  end

  // Connection store: not cleared by reset, software loads it
  always_ff @(posedge clk_i) begin
    if (wr_go && cs_hit) begin
      if (lnk.rq_addr[0]) begin
        cs_mem[cs_idx][15:8] <= lnk.rq_wdata;
      end else begin
        cs_mem[cs_idx][7:0] <= lnk.rq_wdata;
      end
    end
  end

  // Frame timebase, realigned by every frame sync.
  // An aligned sync lands on unit 0, already counted by the wrap; counting
  // it again would step the frame number twice and break the bank rotation
  wire frame_wrap = lnk.fsync ? (unit_r != 12'h000) : (unit_r == 12'hfff);
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      unit_r <= 12'h000;
      phys_r <= 2'h0;
    end else begin
      unit_r <= lnk.fsync ? 12'h001 : unit_r + 12'h001;
      if (frame_wrap) begin
        phys_r <= phys_r + 2'h1;
      end
    end
  end

  // Data store, four frames deep, banked by Rx virtual frame
  always_ff @(posedge clk_i) begin
    if (rx_slot_done) begin
      ds_mem[{rx_vf, rx_slot}] <= lnk.rx_data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      lfsr_r <= LFSR_SEED;
      tx_data_r <= GEN_IDLE_BYTE;
      tx_stb_r <= 1'b0;
      tx_oe_r <= 1'b0;
    end else begin
      tx_stb_r <= tx_slot_start & tx_enabled;
      if (tx_slot_start) begin
        tx_oe_r <= tx_enabled;
        tx_data_r <= slot_byte;
      end
      // Generator only advances on the slots it feeds
      if (tx_slot_start && cs_pattern && gen_on) begin
        lfsr_r <= lfsr_step8(lfsr_r);
      end else if (!gen_on) begin
        lfsr_r <= LFSR_SEED;
      end
    end
  end

  assign lnk.rs_ack = ack_r;
  assign lnk.rs_rdata = rdata_r;
  assign lnk.tx_data = tx_data_r;
  assign lnk.tx_stb = tx_stb_r;
  assign lnk.tx_oe = tx_oe_r;

endmodule

// ===== tsitx_pkg.sv
package tsitx_pkg;
  // Time unit is one quarter bit at 8.192 Mbits/s; one clock per unit
  localparam real UNIT_NS = 30.5176;
  localparam int FRAME_UNITS = 4096;
  localparam int NUM_SLOTS = 32;
  // All highways of this block run at 2.048 Mbits/s
  localparam logic [12:0] SLOT_UNITS = 13'h0080;
  localparam logic [12:0] LL_GAP_SLOTS = 13'h0100;
  localparam logic [12:0] LL_GAP_FIXED = 13'h0004;
  // Offset difference boundaries: C = +3.90625 us, B = -121.09375 us
  localparam real BOUND_C_US = 3.90625;
  localparam real BOUND_B_US = -121.09375;
  localparam logic signed [12:0] BOUND_C = 13'sd128;
  localparam logic signed [12:0] BOUND_B = -13'sd3968;
  // Device register map
  localparam logic [13:0] REG_GLOBAL_COMMAND = 14'h0000;
  localparam logic [13:0] REG_TEST_COMMAND = 14'h0009;
  localparam logic [13:0] REG_PATTERN_STYLE = 14'h000a;
  localparam logic [13:0] REG_GEN_USER_BYTE = 14'h0012;
  localparam logic [13:0] REG_TX_CFG_BYTE0 = 14'h1000;
  localparam logic [13:0] REG_TX_CFG_BYTE1 = 14'h1001;
  localparam logic [13:0] REG_TX_CFG_BYTE2 = 14'h1002;
  localparam logic [13:0] REG_RX_CFG_BYTE0 = 14'h1080;
  localparam logic [13:0] REG_RX_CFG_BYTE1 = 14'h1081;
  localparam logic [13:0] CS_BASE = 14'h2000;
  // Field positions
  localparam int GLOBAL_TX_EN_BIT = 0;
  localparam int GEN_START_BIT = 7;
  localparam int GEN_RATE_LSB = 4;
  localparam int PAT_SEL_LSB = 4;
  localparam int HW_TX_EN_BIT = 2;
  localparam int HW_INDEX_LSB = 3;
  localparam int CS_FP_BIT = 8;
  localparam int CS_SRC_SEL_LSB = 13;
  localparam logic [2:0] SRC_SEL_PATTERN = 3'h6;
  localparam logic [3:0] PAT_USER_BYTE = 4'hf;
  localparam logic [7:0] GEN_IDLE_BYTE = 8'hff;
  localparam logic [14:0] LFSR_SEED = 15'h7fff;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Host side Avalon word map
  localparam logic [2:0] AV_CMD_ADDR = 3'h0;
  localparam logic [2:0] AV_CMD_DATA = 3'h1;
  localparam logic [2:0] AV_CMD_CTRL = 3'h2;
  localparam logic [2:0] AV_RD_DATA = 3'h3;
  localparam logic [2:0] AV_RX_FILL = 3'h4;
  localparam logic [2:0] AV_TX_SEEN = 3'h5;
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_WE_BIT = 1;
endpackage

// ===== tsitx_if.sv
`timescale 1ns/10ps
interface tsitx_if;
  // Register port
  logic rq;
  logic rq_we;
  logic [13:0] rq_addr;
  logic [7:0] rq_wdata;
  logic rs_ack;
  logic [7:0] rs_rdata;
  // Highway side
  logic fsync;
  logic [7:0] rx_data;
  logic [7:0] tx_data;
  logic tx_stb;
  logic tx_oe;
  modport dev (
    input rq, rq_we, rq_addr, rq_wdata, fsync, rx_data,
    output rs_ack, rs_rdata, tx_data, tx_stb, tx_oe
  );
  modport host (
    output rq, rq_we, rq_addr, rq_wdata, fsync, rx_data,
    input rs_ack, rs_rdata, tx_data, tx_stb, tx_oe
  );
endinterface

// ===== tsitx_host.sv
`timescale 1ns/10ps
module tsitx_host
  import tsitx_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Avalon-MM slave
  input wire logic [2:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Host end of the link
  tsitx_if.host lnk
);

  logic wait_r;
  logic [31:0] rdata_r;
  logic [13:0] cmd_addr_r;
  logic [7:0] cmd_data_r;
  logic cmd_we_r;
  logic rq_r;
  logic [7:0] rd_data_r;
  logic [7:0] rx_fill_r;
  logic [7:0] tx_seen_r;
  logic [11:0] fcnt_r;
  logic fsync_r;

  wire av_req = avs_read_i | avs_write_i;
  wire av_wr = avs_write_i & ~wait_r;
  // A new command is ignored while one is still in flight
  wire go = av_wr && (avs_address_i == AV_CMD_CTRL) && avs_writedata_i[CTRL_GO_BIT] && !rq_r;

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (avs_address_i == AV_CMD_ADDR) begin
      rd_mux = {18'h00000, cmd_addr_r};
    end else if (avs_address_i == AV_CMD_DATA) begin
      rd_mux = {24'h000000, cmd_data_r};
    end else if (avs_address_i == AV_CMD_CTRL) begin
      rd_mux = {30'h00000000, cmd_we_r, rq_r};
    end else if (avs_address_i == AV_RD_DATA) begin
      rd_mux = {24'h000000, rd_data_r};
    end else if (avs_address_i == AV_RX_FILL) begin
      rd_mux = {24'h000000, rx_fill_r};
    end else if (avs_address_i == AV_TX_SEEN) begin
      rd_mux = {24'h000000, tx_seen_r};
    end
  end

  // One wait cycle, then the access completes
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else begin
      wait_r <= ~(av_req & wait_r);
      if (av_req && wait_r) begin
        rdata_r <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cmd_addr_r <= 14'h0000;
      cmd_data_r <= REG_RESET;
      cmd_we_r <= 1'b0;
      rx_fill_r <= REG_RESET;
    end else if (av_wr) begin
      if (avs_address_i == AV_CMD_ADDR) begin
        cmd_addr_r <= avs_writedata_i[13:0];
      end else if (avs_address_i == AV_CMD_DATA) begin
        cmd_data_r <= avs_writedata_i[7:0];
      end else if (go) begin
        cmd_we_r <= avs_writedata_i[CTRL_WE_BIT];
      end else if (avs_address_i == AV_RX_FILL) begin
        rx_fill_r <= avs_writedata_i[7:0];
      end
    end
  end

  // Device register access: request held until acknowledged; the host
  // obeys the one-run marking and clear-before-move duties by software
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rq_r <= 1'b0;
      rd_data_r <= REG_RESET;
    end else if (go) begin
      rq_r <= 1'b1;
    end else if (rq_r && lnk.rs_ack) begin
      rq_r <= 1'b0;
      if (!cmd_we_r) begin
        rd_data_r <= lnk.rs_rdata;
      end
    end
  end

  // Frame sync generator and Tx capture
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      fcnt_r <= 12'h000;
      fsync_r <= 1'b0;
      tx_seen_r <= REG_RESET;
    end else begin
      fcnt_r <= fcnt_r + 12'h001;
      fsync_r <= (fcnt_r == 12'hfff);
      if (lnk.tx_stb && lnk.tx_oe) begin
        tx_seen_r <= lnk.tx_data;
      end
    end
  end

  assign avs_readdata_o = rdata_r;
  assign avs_waitrequest_o = wait_r;
  assign lnk.rq = rq_r;
  assign lnk.rq_we = cmd_we_r;
  assign lnk.rq_addr = cmd_addr_r;
  assign lnk.rq_wdata = cmd_data_r;
  assign lnk.fsync = fsync_r;
  assign lnk.rx_data = rx_fill_r;

endmodule

// ===== tsitx_assertions.sv
`timescale 1ns/10ps
module tsitx_assertions (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Link signals
  input wire logic rq,
  input wire logic rq_we,
  input wire logic rs_ack,
  input wire logic fsync,
  input wire logic [7:0] tx_data,
  input wire logic tx_stb,
  input wire logic tx_oe
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // The test moves the Tx offset in whole slots only, so the slot grid never shifts
  logic [7:0] gap_r;
  logic [7:0] gap_nxt;
  logic seen_r;
  assign gap_nxt = tx_stb ? 8'h00 : (gap_r == 8'hff ? gap_r : gap_r + 8'h01);
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      gap_r <= 8'h00;
      seen_r <= 1'b0;
    end else begin
      gap_r <= gap_nxt;
      seen_r <= seen_r | tx_stb;
    end
  end
  property p_stb_oe;
    tx_stb |-> tx_oe;
  endproperty
  a_stb_oe: assert property (p_stb_oe) else $error("strobe without enable");
  property p_oe_hold;
    tx_stb |=> tx_oe [*8];
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("enable dropped in slot");
  property p_gap;
    tx_stb && seen_r |-> gap_r == 8'h7f;
  endproperty
  a_gap: assert property (p_gap) else $error("slot spacing wrong");
  property p_data_hold;
    tx_stb |=> $stable(tx_data) [*8];
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("slot byte changed");
  property p_ack_next;
    rq && !rs_ack |=> rs_ack;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("register answer late");
  property p_ack_pulse;
    rs_ack |=> !rs_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("answer too long");
  property p_ack_idle;
    !rq |=> !rs_ack;
  endproperty
  a_ack_idle: assert property (p_ack_idle) else $error("answer without request");
  property p_rst_quiet;
    $fell(sys_rst_i) |-> tx_data == 8'hff && !tx_oe && !tx_stb;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("output live at reset");
  c_slot: cover property (fsync ##1 tx_stb);
  c_wr: cover property (rs_ack && rq_we);
  c_rd: cover property (rs_ack && !rq_we);
endmodule

// ===== tsi_tx_slot_delay_and_test_gen_tb_top.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tsi_tx_slot_delay_and_test_gen_tb_top
  import tsitx_pkg::*;
();
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [2:0] avs_address_i = 3'h0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [31:0] rdv;
  logic [7:0] seen [32];
  logic [5:0] idx = 6'h0;
  logic [7:0] k = 8'h0;
  int nstb = 0;
  int bad_count = 0;
  int num_checks = 0;
  always #4 clk_i = ~clk_i;
  tsitx_if tsitx_if_i ();
  tsitx_host tsitx_host_i (.clk_i, .sys_rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .lnk(tsitx_if_i.host));
  tsitx_dev tsitx_dev_i (.clk_i, .sys_rst_i, .lnk(tsitx_if_i.dev));
  tsitx_assertions tsitx_assertions_i (.clk_i, .sys_rst_i, .rq(tsitx_if_i.rq),
    .rq_we(tsitx_if_i.rq_we), .rs_ack(tsitx_if_i.rs_ack), .fsync(tsitx_if_i.fsync),
    .tx_data(tsitx_if_i.tx_data), .tx_stb(tsitx_if_i.tx_stb), .tx_oe(tsitx_if_i.tx_oe));
  // Index counts strobes since frame start, so a shifted Tx offset shifts the index
  always @(posedge clk_i) begin
    if (tsitx_if_i.fsync === 1'b1) begin
      idx <= 6'h0;
    end else if (tsitx_if_i.tx_stb === 1'b1) begin
      seen[idx[4:0]] <= tsitx_if_i.tx_data;
      idx <= idx + 6'h1;
      nstb <= nstb + 1;
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic av(input logic w, input logic [2:0] a, input logic [31:0] d);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= ~w;
    @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0) begin
      @(posedge clk_i);
    end
    rdv = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic cmd(input logic w, input logic [13:0] a, input logic [7:0] d);
    av(1'b1, AV_CMD_ADDR, {18'h0, a});
    av(1'b1, AV_CMD_DATA, {24'h0, d});
    av(1'b1, AV_CMD_CTRL, {30'h0, w, 1'b1});
    rdv = 32'h1;
    while (rdv[0] !== 1'b0) begin
      av(1'b0, AV_CMD_CTRL, 32'h0);
    end
    if (w === 1'b0) av(1'b0, AV_RD_DATA, 32'h0);
  endtask
  task automatic frames(input int n);
    repeat (n) begin
      @(posedge clk_i iff tsitx_if_i.fsync === 1'b1);
      k = k + 8'h1;
      av(1'b1, AV_RX_FILL, {24'h0, k});
    end
    @(posedge clk_i iff tsitx_if_i.fsync === 1'b1);
  endtask
  task automatic t_regs();
    logic [4:0] src;
    logic [7:0] b1;
    cmd(1'b1, REG_PATTERN_STYLE, 8'h20);
    cmd(1'b0, REG_PATTERN_STYLE, 8'h00);
    `CHK("style rd", 32'h20, rdv)
    cmd(1'b1, REG_GEN_USER_BYTE, 8'h3c);
    cmd(1'b0, REG_GEN_USER_BYTE, 8'h00);
    `CHK("user rd", 32'h3c, rdv)
    cmd(1'b0, 14'h0003, 8'h00);
    `CHK("dev unmapped", 32'h0, rdv)
    av(1'b0, 3'h6, 32'h0);
    `CHK("av unmapped", 32'h0, rdv)
    for (int s = 0; s < 32; s++) begin
      src = s[4:0];
      b1 = 8'h00;
      if (s == 31 || s == 3) src = 5'h0;
      if (s == 30) src = 5'h1;
      if (s == 0) src = 5'h3;
      if (s == 30 || s == 0) b1 = 8'h01;
      if (s >= 10 && s <= 12) b1 = 8'hc0;
      cmd(1'b1, CS_BASE + 14'(2 * s), {3'h0, src});
      cmd(1'b1, CS_BASE + 14'(2 * s + 1), b1);
    end
    $display("regs done");
  endtask
  task automatic t_enable();
    int n0;
    cmd(1'b1, REG_TX_CFG_BYTE2, 8'h28);
    cmd(1'b1, REG_GLOBAL_COMMAND, 8'h01);
    n0 = nstb;
    frames(1);
    `CHK("global only", n0, nstb)
    cmd(1'b1, REG_GLOBAL_COMMAND, 8'h00);
    cmd(1'b1, REG_TX_CFG_BYTE2, 8'h2c);
    frames(1);
    `CHK("highway only", n0, nstb)
    cmd(1'b1, REG_GLOBAL_COMMAND, 8'h01);
    frames(1);
    `CHK("gen idle", GEN_IDLE_BYTE, seen[10])
    `CHK("both on", 1'b1, tsitx_if_i.tx_oe)
    cmd(1'b1, REG_TEST_COMMAND, 8'h90);
    $display("enable done");
  endtask
  // Lag entries are for Tx slots 31, 2, 3, 30, 0, 13; 9 means not judged for slots 31, 2, 3 and 13
  task automatic run(input string nm, input logic [11:0] to, input logic [11:0] ro,
      input int s, input logic [3:0] p, input logic [7:0] pb, input int lg [6]);
    int sl [6];
    sl = '{31, 2, 3, 30, 0, 13};
    cmd(1'b1, REG_TX_CFG_BYTE0, to[7:0]);
    cmd(1'b1, REG_TX_CFG_BYTE1, {4'h0, to[11:8]});
    cmd(1'b1, REG_RX_CFG_BYTE0, ro[7:0]);
    cmd(1'b1, REG_RX_CFG_BYTE1, {4'h0, ro[11:8]});
    cmd(1'b1, REG_PATTERN_STYLE, {p, 4'h0});
    frames(2);
    for (int q = 0; q < 6; q++) begin
      if ((q < 3 || q == 5) && lg[q] < 9)
        `CHK(nm, k - 8'(lg[q]), seen[(sl[q] + s) % 32])
      if (q == 3 || q == 4)
        `CHK(nm, k - 8'(lg[q]), seen[sl[q] + s])
    end
    for (int j = 10; j < 13; j++)
      `CHK(nm, pb, seen[j + s])
    $display("%s done", nm);
  endtask
  task automatic t_zero();
    run("zero", 12'h0, 12'h0, 0, 4'h0, 8'h00, '{0, 1, 0, 2, 2, 1});
  endtask
  task automatic t_guard_in();
    run("guard in", 12'h0, 12'h077, 0, 4'h1, 8'hff, '{0, 1, 0, 2, 2, 1});
  endtask
  task automatic t_guard_out();
    run("guard out", 12'h0, 12'h078, 0, 4'h2, 8'h55, '{0, 1, 1, 2, 2, 1});
  endtask
  task automatic t_late_rx();
    run("late rx", 12'h0, 12'hfa0, 0, 4'h3, 8'haa, '{9, 9, 9, 2, 2, 9});
  endtask
  task automatic t_early_tx();
    run("early tx", 12'h080, 12'h0, 1, 4'hf, 8'h3c, '{9, 1, 0, 1, 1, 1});
  endtask
  // Marks are cleared before any move; freed slots go back to switched data,
  // which under the early Tx offset is one frame late
  task automatic t_unmark();
    for (int j = 10; j < 13; j++)
      cmd(1'b1, CS_BASE + 14'(2 * j + 1), 8'h00);
    frames(1);
    for (int j = 10; j < 13; j++)
      `CHK("unmarked", k - 8'h1, seen[j + 1])
    av(1'b0, AV_TX_SEEN, 32'h0);
    `CHK("tx seen", {24'h0, k - 8'h1}, rdv)
    $display("unmark done");
  endtask
  initial begin
    #880000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK("rst wait", 1'b1, avs_waitrequest_o)
    `CHK("rst txd", 8'hff, tsitx_if_i.tx_data)
    t_regs();
    t_enable();
    t_zero();
    t_guard_in();
    t_guard_out();
    t_late_rx();
    t_early_tx();
    t_unmark();
    report_and_stop();
  end
endmodule
